// File: hdl/edge_decoder.sv
// edge decoder: quadrature or frequency/direction into signed count steps
module edge_decoder (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // synchronised track inputs
  input  wire logic       trk_a,
  input  wire logic       trk_b,
  // configuration
  input  wire logic [1:0] in_type,
  // step outputs
  output logic            step,
  output logic            step_up
);
  logic a_q;       // previous track a
  logic b_q;       // previous track b
  logic next_a_q;
  logic next_b_q;

  // combinational step decode
  always_comb
  begin
    next_a_q = trk_a;
    next_b_q = trk_b;
    step     = 1'b0;
    step_up  = 1'b0;
    case (in_type)
      freq_ref_pkg::IN_QUAD:
      begin
        // every single-track edge counts; direction from phase order
        if ((trk_a ^ a_q) && !(trk_b ^ b_q))
        begin
          step    = 1'b1;
          step_up = trk_a ^ trk_b;
        end
        else if ((trk_b ^ b_q) && !(trk_a ^ a_q))
        begin
          step    = 1'b1;
          step_up = ~(trk_a ^ trk_b);
        end
      end
      freq_ref_pkg::IN_FD_ALL, freq_ref_pkg::IN_ANALOG:
      begin
        // analog option arrives as a converted frequency on track a
        step    = trk_a ^ a_q;
        step_up = trk_b;
      end
      freq_ref_pkg::IN_FD_RISE:
      begin
        step    = trk_a & ~a_q;
        step_up = trk_b;
      end
      default:
      begin
        step    = 1'b0;
        step_up = 1'b0;
      end
    endcase
  end

  // track history registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      a_q <= 1'b0;
      b_q <= 1'b0;
    end
    else
    begin
      a_q <= next_a_q;
      b_q <= next_b_q;
    end
  end
endmodule

// File: hdl/freq_ref_pkg.sv
// package of constants for the frequency speed reference input
package freq_ref_pkg;
  // input type selector codes
  localparam logic [1:0] IN_ANALOG   = 2'h0;
  localparam logic [1:0] IN_QUAD     = 2'h1;
  localparam logic [1:0] IN_FD_ALL   = 2'h2;
  localparam logic [1:0] IN_FD_RISE  = 2'h3;
  // reference mode selector codes
  localparam logic [1:0] MODE_PULSE  = 2'h0;
  localparam logic [1:0] MODE_TIME   = 2'h1;
  localparam logic [1:0] MODE_BOTH   = 2'h2;
  // analog ratio mode that takes the numerator from an analog input
  localparam logic [1:0] RATIO_ANALOG = 2'h2;
  // pulses per revolution: selector 1 gives 64, doubling per step up to 9
  localparam logic [3:0] PPR_SEL_MAX = 4'h9;
  localparam int         PPR_BASE_LOG2 = 6;
  // ratio limits and defaults
  localparam logic [13:0] RATIO_MAX     = 14'h3FFF;
  localparam logic [13:0] RATIO_DEFAULT = 14'h0064;
  // analog offset trim range, 1/100 mV units
  localparam int OFFSET_LIMIT = 19999;
  // voltage at max speed range, mV
  localparam logic [13:0] VMAX_MIN = 14'h09C4;
  localparam logic [13:0] VMAX_MAX = 14'h2710;
  // seconds per minute
  localparam logic [5:0] SEC_PER_MIN = 6'h3C;
  // clock and timer figures
  localparam int CLK_PERIOD_NS  = 20;
  localparam int TIMER_RES_NS   = 25;
  // one timer tick per clock: a 20 ns clock is already finer than the 25 ns needed,
  // and the time reference treats the interval as a count of clocks
  localparam int TIMER_TICK_CYC = 1;
  localparam int CLK_HZ         = 1000000000 / CLK_PERIOD_NS;
  // widths
  localparam int CNT_W  = 16;
  localparam int TIME_W = 24;
  localparam int SPD_W  = 32;
  // interval timer saturation value
  localparam logic [23:0] TIME_SAT = 24'hFFFFFF;
endpackage

// File: hdl/freq_speed_reference_input.sv
// frequency speed reference input: pulse count and time-decoded speed references
// Overview of operation
// - four input types chosen by input-type selector
// - type 2 counts all edges, type 3 rising
// - reference used only when setting or input enables
// - incremental position path always enabled, offset optional
// - ppr selector 0 disables, 1..9 gives 64..16384
// - rpm equals f times 60 times num over ppr-den
// - analog ratio mode 2 takes numerator from analog
// - edges counted each PWM period, none lost
// - interval between edges timed at one 20 ns clock, finer than the 25 ns needed
// - time reference reaches 1/8000 at 5 kHz PWM
// - mode selects pulse, time or both references
// - pulse mode feeds counts directly, ramps off
// - time mode uses interval reference, ramps allowed
// - combined mode: time main, pulses to integral
// - combined mode ramps only during first start
// - analog option converts to frequency, offset compensated
// - volts-at-max-speed maps voltage to max speed
// - ratio values limited to 16383, default 100
// - analog offset signed within 19999 hundredths mV
// - volts-at-max-speed limited 2500 to 10000 mV
module freq_speed_reference_input (
  // clock and reset
  input  wire logic               I_REF_CLK,
  input  wire logic               I_NRST,
  // pulse inputs from the source (asynchronous pins)
  input  wire logic               I_TRACK_A,
  input  wire logic               I_TRACK_B,
  // pwm sampling period strobe (same clock domain)
  input  wire logic               I_PWM_SAMPLE,
  // configuration settings
  input  wire logic [1:0]         I_PULSE_INPUT_TYPE_SEL,
  input  wire logic [3:0]         I_PULSES_PER_REV_SEL,
  input  wire logic [13:0]        I_RATIO_NUMERATOR,
  input  wire logic [13:0]        I_RATIO_DENOMINATOR,
  input  wire logic               I_FREQ_REF_ENABLE_SETTING,
  input  wire logic               I_FREQ_REF_ENABLE_INPUT_FN,
  input  wire logic [1:0]         I_REF_MODE_SEL,
  input  wire logic [1:0]         I_RATIO_ANALOG_MODE,
  input  wire logic [13:0]        I_RATIO_ANALOG_VALUE,
  input  wire logic               I_RAMP_ENABLE,
  input  wire logic               I_RUN,
  // analog option settings
  input  wire logic signed [15:0] I_ANALOG_OFFSET_TRIM,
  input  wire logic [13:0]        I_VOLTS_AT_MAX_SPEED,
  // outputs
  output logic signed [31:0]      O_COUNTED_PULSE_SPEED_REF,
  output logic signed [31:0]      O_TIME_DECODED_SPEED_REF,
  output logic signed [31:0]      O_MAIN_SPEED_REF,
  output logic signed [31:0]      O_INTEGRAL_SPEED_REF,
  output logic signed [31:0]      O_POSITION_COUNT,
  output logic                    O_RAMP_ACTIVE,
  output logic                    O_REF_ACTIVE,
  output logic signed [15:0]      O_ANALOG_OFFSET,
  output logic [13:0]             O_VOLTS_AT_MAX_SPEED
);
  // reset synchroniser
  logic [1:0] rst_sync;
  logic       rst_n;
  // pin synchronisers; first stage read only by the second
  logic [1:0] a_sync;
  logic [1:0] b_sync;
  // decoder outputs
  logic       step;
  logic       step_up;
  // ratio values after clamping
  logic [13:0] num_eff;
  logic [13:0] den_eff;
  logic [4:0]  ppr_log2;
  logic        ppr_ok;
  logic        enabled;
  // pulse counting state
  logic signed [15:0] period_cnt;
  logic signed [15:0] next_period_cnt;
  logic signed [31:0] pos_cnt;
  logic signed [31:0] next_pos_cnt;
  logic signed [31:0] pulse_ref;
  logic signed [31:0] next_pulse_ref;
  // time decoding state
  logic [23:0]        interval;
  logic [23:0]        next_interval;
  logic [23:0]        last_interval;
  logic [23:0]        next_last_interval;
  logic               last_up;
  logic               next_last_up;
  logic signed [31:0] time_ref;
  logic signed [31:0] next_time_ref;
  // ramp state
  logic               started;
  logic               next_started;
  // scaling scratch
  logic [63:0]        scale_num;
  logic [63:0]        time_mag;
  logic [63:0]        pulse_mag;

  // reset release through two flops
  always_ff @(posedge I_REF_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // two-flop synchronisers on the pulse pins
  always_ff @(posedge I_REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      a_sync <= 2'h0;
      b_sync <= 2'h0;
    end
    else
    begin
      a_sync <= {a_sync[0], I_TRACK_A};
      b_sync <= {b_sync[0], I_TRACK_B};
    end
  end

  // edge decoding per input type
  edge_decoder u_dec (
    .clk     (I_REF_CLK),
    .rst_n   (rst_n),
    .trk_a   (a_sync[1]),
    .trk_b   (b_sync[1]),
    .in_type (I_PULSE_INPUT_TYPE_SEL),
    .step    (step),
    .step_up (step_up)
  );

  // settings clamped to their legal ranges
  always_comb
  begin
    // numerator from analog when analog ratio mode is chosen
    if (I_RATIO_ANALOG_MODE == freq_ref_pkg::RATIO_ANALOG)
      num_eff = I_RATIO_ANALOG_VALUE;
    else
      num_eff = I_RATIO_NUMERATOR;
    // 14-bit ports already cap at 16383; zero denominator would divide by zero
    den_eff = (I_RATIO_DENOMINATOR == 14'h0000) ? 14'h0001 : I_RATIO_DENOMINATOR;
    // ppr selector: 0 and out-of-range disable
    ppr_ok   = (I_PULSES_PER_REV_SEL != 4'h0) &&
               (I_PULSES_PER_REV_SEL <= freq_ref_pkg::PPR_SEL_MAX);
    ppr_log2 = 5'(I_PULSES_PER_REV_SEL) + 5'(freq_ref_pkg::PPR_BASE_LOG2 - 1);
    enabled  = (I_FREQ_REF_ENABLE_SETTING | I_FREQ_REF_ENABLE_INPUT_FN) & ppr_ok;
  end

  // analog option settings, clamped
  always_comb
  begin
    if (I_ANALOG_OFFSET_TRIM > 16'(freq_ref_pkg::OFFSET_LIMIT))
      O_ANALOG_OFFSET = 16'(freq_ref_pkg::OFFSET_LIMIT);
    else if (I_ANALOG_OFFSET_TRIM < -16'(freq_ref_pkg::OFFSET_LIMIT))
      O_ANALOG_OFFSET = -16'(freq_ref_pkg::OFFSET_LIMIT);
    else
      O_ANALOG_OFFSET = I_ANALOG_OFFSET_TRIM;
    if (I_VOLTS_AT_MAX_SPEED < freq_ref_pkg::VMAX_MIN)
      O_VOLTS_AT_MAX_SPEED = freq_ref_pkg::VMAX_MIN;
    else if (I_VOLTS_AT_MAX_SPEED > freq_ref_pkg::VMAX_MAX)
      O_VOLTS_AT_MAX_SPEED = freq_ref_pkg::VMAX_MAX;
    else
      O_VOLTS_AT_MAX_SPEED = I_VOLTS_AT_MAX_SPEED;
  end

  // next-state for counting, timing and ramp
  always_comb
  begin
    next_period_cnt    = period_cnt;
    next_pos_cnt       = pos_cnt;
    next_pulse_ref     = pulse_ref;
    next_interval      = interval;
    next_last_interval = last_interval;
    next_last_up       = last_up;
    next_time_ref      = time_ref;
    next_started       = started;
    scale_num = 64'(freq_ref_pkg::SEC_PER_MIN) * 64'(num_eff);
    // rpm = edges/s * 60 * num / (ppr * den)
    time_mag  = 64'(freq_ref_pkg::CLK_HZ) * scale_num
                / ((64'(last_interval) * 64'(den_eff)) << ppr_log2);
    pulse_mag = 64'(period_cnt < 0 ? -period_cnt : period_cnt) * scale_num
                / (64'(den_eff) << ppr_log2);
    // position path counts every step regardless of enable
    if (step)
      next_pos_cnt = step_up ? pos_cnt + 32'sd1 : pos_cnt - 32'sd1;
    // interval timer, one tick per clock, saturating when stopped
    if (interval != freq_ref_pkg::TIME_SAT)
      next_interval = interval + 24'(freq_ref_pkg::TIMER_TICK_CYC);
    if (step)
    begin
      next_last_interval = interval;
      next_last_up       = step_up;
      next_interval      = 24'h000001;
    end
    else if (interval == freq_ref_pkg::TIME_SAT)
      next_last_interval = freq_ref_pkg::TIME_SAT; // stopped input falls to the small speed of a saturated interval, not to zero
    // period count: an edge on the sample cycle starts the new period
    if (I_PWM_SAMPLE)
    begin
      next_period_cnt = step ? (step_up ? 16'sd1 : -16'sd1) : 16'sd0;
      next_pulse_ref  = enabled ? (step_up_sign(period_cnt) ? -32'(pulse_mag)
                                                            : 32'(pulse_mag)) : 32'sd0;
      next_time_ref   = (enabled && last_interval != 24'h000000)
                        ? (last_up ? 32'(time_mag) : -32'(time_mag)) : 32'sd0;
    end
    else if (step)
      next_period_cnt = step_up ? period_cnt + 16'sd1 : period_cnt - 16'sd1;
    // first start latch for combined-mode ramps
    if (I_RUN && enabled)
      next_started = 1'b1;
  end

  // sign helper: true when count is negative
  function automatic logic step_up_sign(input logic signed [15:0] v);
    step_up_sign = v[15];
  endfunction

  // state registers
  always_ff @(posedge I_REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      period_cnt    <= 16'sh0000;
      pos_cnt       <= 32'sh00000000;
      pulse_ref     <= 32'sh00000000;
      interval      <= freq_ref_pkg::TIME_SAT;
      last_interval <= freq_ref_pkg::TIME_SAT;
      last_up       <= 1'b1;
      time_ref      <= 32'sh00000000;
      started       <= 1'b0;
    end
    else
    begin
      period_cnt    <= next_period_cnt;
      pos_cnt       <= next_pos_cnt;
      pulse_ref     <= next_pulse_ref;
      interval      <= next_interval;
      last_interval <= next_last_interval;
      last_up       <= next_last_up;
      time_ref      <= next_time_ref;
      started       <= next_started;
    end
  end

  // output selection by reference mode
  always_comb
  begin
    O_COUNTED_PULSE_SPEED_REF = pulse_ref;
    O_TIME_DECODED_SPEED_REF  = time_ref;
    O_POSITION_COUNT          = pos_cnt;
    O_REF_ACTIVE              = enabled;
    case (I_REF_MODE_SEL)
      freq_ref_pkg::MODE_PULSE:
      begin
        O_MAIN_SPEED_REF     = pulse_ref;
        O_INTEGRAL_SPEED_REF = 32'sh00000000;
        O_RAMP_ACTIVE        = 1'b0;
      end
      freq_ref_pkg::MODE_TIME:
      begin
        O_MAIN_SPEED_REF     = time_ref;
        O_INTEGRAL_SPEED_REF = 32'sh00000000;
        O_RAMP_ACTIVE        = I_RAMP_ENABLE;
      end
      freq_ref_pkg::MODE_BOTH:
      begin
        O_MAIN_SPEED_REF     = time_ref;
        O_INTEGRAL_SPEED_REF = pulse_ref;
        O_RAMP_ACTIVE        = I_RAMP_ENABLE & ~started;
      end
      default:
      begin
        O_MAIN_SPEED_REF     = 32'sh00000000;
        O_INTEGRAL_SPEED_REF = 32'sh00000000;
        O_RAMP_ACTIVE        = 1'b0;
      end
    endcase
  end

  // checks on counting, modes and ramps
  a_pulse_mode_noramp: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
    I_REF_MODE_SEL == freq_ref_pkg::MODE_PULSE |-> !O_RAMP_ACTIVE)
    else $error("ramp active in pulse mode");
  a_disabled_ref_zero: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
    (I_PWM_SAMPLE && !enabled) |=> (pulse_ref == 0 && time_ref == 0))
    else $error("reference not zero when disabled");
  a_position_counts: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
    (step && step_up) |=> pos_cnt == $past(pos_cnt) + 1)
    else $error("position did not count up");
  a_period_restart: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
    (I_PWM_SAMPLE && !step) |=> period_cnt == 0)
    else $error("period count not restarted");
  a_interval_capture: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
    step |=> (last_interval == $past(interval) && interval == 1))
    else $error("interval not captured");
  a_combined_ramp_once: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
    (started && I_REF_MODE_SEL == freq_ref_pkg::MODE_BOTH) |-> !O_RAMP_ACTIVE)
    else $error("ramp after first start");
  a_combined_paths: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
    I_REF_MODE_SEL == freq_ref_pkg::MODE_BOTH |->
      (O_MAIN_SPEED_REF == time_ref && O_INTEGRAL_SPEED_REF == pulse_ref))
    else $error("combined mode routing wrong");
  a_ppr_zero_off: assert property (@(posedge I_REF_CLK) disable iff (!rst_n)
    I_PULSES_PER_REV_SEL == 4'h0 |-> !O_REF_ACTIVE)
    else $error("reference active with ppr zero");
  c_pulse_sample: cover property (@(posedge I_REF_CLK) disable iff (!rst_n)
    I_PWM_SAMPLE && enabled && period_cnt != 0);
  c_combined_start: cover property (@(posedge I_REF_CLK) disable iff (!rst_n)
    I_REF_MODE_SEL == freq_ref_pkg::MODE_BOTH && $rose(started));
  c_count_down: cover property (@(posedge I_REF_CLK) disable iff (!rst_n) step && !step_up);
endmodule

// File: tb/pulse_source.sv
// behavioural pulse source: master encoder or frequency plus direction generator
module pulse_source (
  // clock of the bench
  input  wire logic       i_clk,
  // burst request and shape
  input  wire logic       i_go,
  input  wire logic       i_quad,
  input  wire logic       i_up,
  input  wire logic [7:0] i_edges,
  input  wire logic [7:0] i_gap,
  // pins towards the drive
  output logic            o_track_a,
  output logic            o_track_b,
  // burst still running
  output logic            o_busy
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] left;  // edges still to send
  logic [7:0] cnt;   // cycles until the next edge

  initial
  begin
    o_track_a = 1'b0;
    o_track_b = 1'b0;
    o_busy    = 1'b0;
    left      = 8'h00;
    cnt       = 8'h00;
  end

  // one edge every i_gap cycles; callers keep i_gap at 42 or more
  always @(posedge i_clk)
  begin
    if (i_go)
    begin
      o_busy <= 1'b1;
      left   <= i_edges;
      cnt    <= i_gap;
      // direction level settles long before the first counted edge
      if (!i_quad)
        o_track_b <= i_up;
    end
    else if (o_busy)
    begin
      if (cnt > 8'h01)
        cnt <= cnt - 8'h01;
      else
      begin
        cnt  <= i_gap;
        left <= left - 8'h01;
        if (left == 8'h01)
          o_busy <= 1'b0;
        // frequency pin only toggles; quadrature keeps the phase order
        if (!i_quad)
          o_track_a <= ~o_track_a;
        else if ((o_track_a == o_track_b) == i_up)
          o_track_a <= ~o_track_a;
        else
          o_track_b <= ~o_track_b;
      end
    end
  end
endmodule

// File: tb/tb_freq_speed_reference_input.sv
// self-checking bench for the frequency speed reference input
`define CHK(nm, ex, gt) \
  begin \
    cmp_count++; \
    if ((gt) !== (ex)) \
    begin \
      fail_count++; \
      $display("BAD %s expected %0d seen %0d", nm, ex, gt); \
    end \
  end

module tb_freq_speed_reference_input;
  timeunit 1ns;
  timeprecision 100ps;

  // clock, reset and sampling strobe
  logic               clk, nrst, pwm_s;
  // configuration driven by the bench
  logic [1:0]         in_type, mode, ratio_mode;
  logic [3:0]         ppr_sel;
  logic [13:0]        num, den, aval, vmax;
  logic               en_set, en_fn, ramp_en, run;
  logic signed [15:0] trim;
  // pulse source control and pins
  logic               go, up, quad, trk_a, trk_b, busy;
  logic [7:0]         gap;
  // observed outputs
  logic signed [31:0] cp, td, mn, ig, pc;
  logic               ramp, ref_act;
  logic signed [15:0] offs;
  logic [13:0]        vout;
  // bookkeeping
  int                 fail_count, cmp_count, cyc;
  logic signed [31:0] exp_pos, acc;

  assign quad = (in_type == freq_ref_pkg::IN_QUAD);

  freq_speed_reference_input u_freq_speed_reference_input (
    .I_REF_CLK(clk), .I_NRST(nrst), .I_TRACK_A(trk_a), .I_TRACK_B(trk_b),
    .I_PWM_SAMPLE(pwm_s), .I_PULSE_INPUT_TYPE_SEL(in_type), .I_PULSES_PER_REV_SEL(ppr_sel),
    .I_RATIO_NUMERATOR(num), .I_RATIO_DENOMINATOR(den), .I_FREQ_REF_ENABLE_SETTING(en_set),
    .I_FREQ_REF_ENABLE_INPUT_FN(en_fn), .I_REF_MODE_SEL(mode), .I_RATIO_ANALOG_MODE(ratio_mode),
    .I_RATIO_ANALOG_VALUE(aval), .I_RAMP_ENABLE(ramp_en), .I_RUN(run),
    .I_ANALOG_OFFSET_TRIM(trim), .I_VOLTS_AT_MAX_SPEED(vmax),
    .O_COUNTED_PULSE_SPEED_REF(cp), .O_TIME_DECODED_SPEED_REF(td), .O_MAIN_SPEED_REF(mn),
    .O_INTEGRAL_SPEED_REF(ig), .O_POSITION_COUNT(pc), .O_RAMP_ACTIVE(ramp),
    .O_REF_ACTIVE(ref_act), .O_ANALOG_OFFSET(offs), .O_VOLTS_AT_MAX_SPEED(vout)
  );

  pulse_source u_pulse_source (
    .i_clk(clk), .i_go(go), .i_quad(quad), .i_up(up), .i_edges(8'h40), .i_gap(gap),
    .o_track_a(trk_a), .o_track_b(trk_b), .o_busy(busy)
  );

  // free running 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // hang guard: the whole sequence needs roughly 60000 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      fail_count++;
      report_and_stop();
    end
  end

  // inputs always move 1 ns after the rising edge
  task tick();
    @(posedge clk);
    #1;
  endtask

  // one pwm period boundary; refs are read once the answer stands
  task pwm();
    pwm_s = 1'b1;
    tick();
    pwm_s = 1'b0;
    tick();
  endtask

  // 64 edges at the given spacing; split samples mid-burst and sums the counts
  task burst(input logic dir, input logic [7:0] spacing, input logic split);
    int k;
    k = 0;
    pwm();
    up  = dir;
    gap = spacing;
    go  = 1'b1;
    tick();
    go  = 1'b0;
    acc = 32'sh0;
    while (busy === 1'b1 && k < 20000)
    begin
      tick();
      k++;
      if (split && (k % 700) == 0)
      begin
        pwm();
        acc = acc + cp;
      end
    end
    // three-cycle pin pipeline must drain before the boundary
    repeat (5) tick();
    pwm();
    acc = acc + cp;
  endtask

  // clamp of the analog option settings
  task clamp(input logic signed [15:0] t, input logic [13:0] v,
             input logic signed [15:0] et, input logic [13:0] ev);
    trim = t;
    vmax = v;
    tick();
    `CHK("offset", et, offs)
    `CHK("vmax", ev, vout)
  endtask

  task report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    nrst = 1'b0; pwm_s = 1'b0; go = 1'b0; up = 1'b1; gap = 8'h32;
    in_type = freq_ref_pkg::IN_QUAD; mode = freq_ref_pkg::MODE_PULSE; ratio_mode = 2'h0;
    ppr_sel = 4'h1; num = 14'h0040; den = 14'h003C; aval = 14'h0032; vmax = 14'h1388;
    en_set = 1'b1; en_fn = 1'b0; ramp_en = 1'b1; run = 1'b0; trim = 16'sh0000;
    fail_count = 0; cmp_count = 0; cyc = 0; exp_pos = 32'sh0;
    repeat (4) @(posedge clk);
    #1;
    nrst = 1'b1;
    repeat (4) tick();
    `CHK("pos reset", 0, pc)
    `CHK("pulse reset", 0, cp)
    // ramps: never in pulse mode, allowed in time mode, first start only when combined
    tick();
    `CHK("ramp pulse", 1'b0, ramp)
    mode = freq_ref_pkg::MODE_TIME;
    tick();
    `CHK("ramp time", 1'b1, ramp)
    mode = freq_ref_pkg::MODE_BOTH;
    tick();
    `CHK("ramp first", 1'b1, ramp)
    run = 1'b1;
    repeat (3) tick();
    run = 1'b0;
    tick();
    `CHK("ramp after", 1'b0, ramp)
    // clamp boundaries on both sides and a plain value
    clamp(16'sd20000, 14'd1000, 16'sd19999, 14'd2500);
    clamp(-16'sd25000, 14'd12000, -16'sd19999, 14'd10000);
    clamp(16'sd123, 14'd5000, 16'sd123, 14'd5000);
    // quadrature up; ratio 64/60 at 64 ppr makes the pulse ref equal the count
    burst(1'b1, 8'h32, 1'b0);
    exp_pos = exp_pos + 64;
    `CHK("quad up pulses", 64, cp)
    `CHK("quad up time", 1000000, td)
    `CHK("both main", 1000000, mn)
    `CHK("both integral", 64, ig)
    `CHK("pos up", exp_pos, pc)
    mode = freq_ref_pkg::MODE_PULSE;
    tick();
    `CHK("pulse main", 64, mn)
    mode = freq_ref_pkg::MODE_TIME;
    tick();
    `CHK("time main", 1000000, mn)
    mode = 2'h3;
    tick();
    `CHK("mode 3 main", 0, mn)
    mode = freq_ref_pkg::MODE_BOTH;
    // reverse phase order counts down
    burst(1'b0, 8'h32, 1'b0);
    exp_pos = exp_pos - 64;
    `CHK("quad dn pulses", -64, cp)
    `CHK("quad dn time", -1000000, td)
    `CHK("pos dn", exp_pos, pc)
    // boundaries inside the burst must not lose any edge
    burst(1'b1, 8'h32, 1'b1);
    exp_pos = exp_pos + 64;
    `CHK("split sum", 64, acc)
    // every ppr step; numerator tracks ppr so refs stay constant
    for (int s = 1; s <= 9; s++)
    begin
      ppr_sel = 4'(s);
      num     = 14'h0001 << (s - 1);
      burst(1'b1, 8'h32, 1'b0);
      exp_pos = exp_pos + 64;
      `CHK("ppr pulses", 1, cp)
      `CHK("ppr time", 15625, td)
    end
    ppr_sel = 4'h1;
    num     = 14'h0040;
    // numerator taken from the analog value
    ratio_mode = freq_ref_pkg::RATIO_ANALOG;
    burst(1'b1, 8'h32, 1'b0);
    exp_pos = exp_pos + 64;
    `CHK("analog num pulses", 50, cp)
    `CHK("analog num time", 781250, td)
    ratio_mode = 2'h0;
    // disabled reference still moves the position count
    en_set = 1'b0;
    burst(1'b1, 8'h32, 1'b0);
    exp_pos = exp_pos + 64;
    `CHK("off active", 1'b0, ref_act)
    `CHK("off pulses", 0, cp)
    `CHK("off pos", exp_pos, pc)
    en_fn = 1'b1;
    tick();
    `CHK("fn active", 1'b1, ref_act)
    ppr_sel = 4'h0;
    tick();
    `CHK("ppr 0 active", 1'b0, ref_act)
    ppr_sel = 4'hA;
    tick();
    `CHK("ppr 10 active", 1'b0, ref_act)
    ppr_sel = 4'h1;
    // frequency plus direction, all edges, both directions
    in_type = freq_ref_pkg::IN_FD_ALL;
    burst(1'b0, 8'h32, 1'b0);
    exp_pos = exp_pos - 64;
    `CHK("fd dn pulses", -64, cp)
    `CHK("fd dn pos", exp_pos, pc)
    burst(1'b1, 8'h32, 1'b0);
    exp_pos = exp_pos + 64;
    `CHK("fd up pulses", 64, cp)
    // rising edges only: half the count, double the interval
    in_type = freq_ref_pkg::IN_FD_RISE;
    burst(1'b1, 8'h32, 1'b0);
    exp_pos = exp_pos + 32;
    `CHK("rise pulses", 32, cp)
    `CHK("rise time", 500000, td)
    `CHK("rise pos", exp_pos, pc)
    // converted analog frequency counted through the same path
    in_type = freq_ref_pkg::IN_ANALOG;
    burst(1'b1, 8'h32, 1'b0);
    exp_pos = exp_pos + 64;
    `CHK("analog pulses", 64, cp)
    `CHK("analog pos", exp_pos, pc)
    report_and_stop();
  end
endmodule
